// File: design/swc_cfg.svh
// swc_cfg.svh: opcodes, register indices, flag bit positions and reset values
// assumes: included by bare name from swc_engine only, not from the package or swc_regmem
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH

// ==========================================================
// opcodes
`define SWC_OP_SET_WE 8'h06
`define SWC_OP_MEM_WRITE 8'h02
`define SWC_OP_CLK_READ 8'h13
`define SWC_OP_CLK_FREAD 8'h1d
`define SWC_OP_CLK_WRITE 8'h12
`define SWC_OP_SAVE 8'h3c
`define SWC_OP_RESTORE 8'h60
`define SWC_OP_AUTO_ON 8'h59
`define SWC_OP_AUTO_OFF 8'h19

// ==========================================================
// clock register map
`define SWC_FLAG_IDX 4'h0
`define SWC_TIME_FIRST 4'h1
`define SWC_TIME_LAST 4'h7
`define SWC_FLAG_R 0
`define SWC_FLAG_W 1
`define SWC_FLAG_RST 8'h00

// ==========================================================
// memory array and protection
`define SWC_QUARTER_BASE 17'h18000
`define SWC_AUTOSAVE_RST 1'b1

`endif

// File: design/swc_engine.sv
// swc_engine: serial slave command engine for memory writes, clock registers
// and the save, restore and autosave commands
// assumes: mode 0 serial link sampled by mclk, link clock well below mclk/8
`timescale 1ns/100ps
`include "swc_cfg.svh"
module swc_engine (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic [1:0] blk_prot,
    input wire swc_pkg::swc_time_t live_time,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [16:0] mem_wr_addr,
    output logic [7:0] mem_wr_data,
    output logic wr_overrun,
    output logic write_enable,
    output logic autosave_on,
    output logic save_req,
    output logic restore_req,
    output logic time_load,
    output swc_pkg::swc_time_t time_load_data
);
    import swc_pkg::*;

    // ==========================================================
    // pin synchronisers and edge detect
    logic [1:0] cs_s, sck_s, si_s;
    logic sck_d;
    logic cs_lo, sck_rise, sck_fall;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {cs_s, sck_s, si_s, sck_d} <= 7'h60;
        end else begin
            {cs_s, sck_s, si_s, sck_d} <= {cs_s[0], cs_n, sck_s[0], sck, si_s[0], si, sck_s[1]};
        end
    end

    assign cs_lo = !cs_s[1];
    assign sck_rise = sck_s[1] && !sck_d;
    assign sck_fall = !sck_s[1] && sck_d;

    // ==========================================================
    // command state
    swc_state_t state, next_state;
    logic [2:0] bitcnt, next_bitcnt;
    logic [7:0] rx, next_rx, opc, next_opc, tx, next_tx, flags, next_flags;
    logic [16:0] addr, next_addr;
    logic [1:0] abyte, next_abyte;
    logic [3:0] caddr, next_caddr;
    logic wen, next_wen, wcmd, next_wcmd, auto_q, next_auto;
    logic so_q, next_so, oe_q, next_oe;
    logic save_q, next_save, rest_q, next_rest, load_q, next_load;
    swc_time_t snap, next_snap, stage, next_stage;
    logic [7:0] byte_in, rbyte;
    logic [2:0] kidx;
    logic byte_done, push, push_ok;
    swc_wr_t push_data;
    swc_regmem_if rm ();

    swc_regmem #(.DEPTH(16)) u_regmem (
        .mclk(mclk),
        .rst(rst),
        .m(rm.ctl)
    );

    function automatic logic is_prot(input logic [1:0] bp, input logic [16:0] a);
        is_prot = (bp == 2'h3) || (bp == 2'h2 && a[16]) ||
                  (bp == 2'h1 && a >= `SWC_QUARTER_BASE);
    endfunction : is_prot

    assign byte_in = {rx[6:0], si_s[1]};
    assign byte_done = sck_rise && bitcnt == 3'h7;
    assign kidx = caddr[2:0] - 3'h1;
    assign rm.raddr = caddr;
    assign rm.waddr = caddr;
    assign rm.wdata = byte_in;
    assign push_data = {addr, byte_in};

    // read data of the addressed clock register
    always_comb begin
        rbyte = rm.rdata;
        if (caddr == `SWC_FLAG_IDX) begin
            rbyte = flags;
        end else if (caddr >= `SWC_TIME_FIRST && caddr <= `SWC_TIME_LAST) begin
            rbyte = flags[`SWC_FLAG_R] ? snap[{kidx, 3'h0} +: 8] : live_time[{kidx, 3'h0} +: 8];
        end
    end

    always_comb begin
        next_state = state;
        next_bitcnt = bitcnt;
        next_rx = rx;
        next_opc = opc;
        next_tx = tx;
        next_flags = flags;
        next_addr = addr;
        next_abyte = abyte;
        next_caddr = caddr;
        next_wen = wen;
        next_wcmd = wcmd;
        next_auto = auto_q;
        next_so = so_q;
        next_oe = oe_q;
        next_save = 1'b0;
        next_rest = 1'b0;
        next_load = 1'b0;
        next_snap = snap;
        next_stage = stage;
        push = 1'b0;
        rm.we = 1'b0;
        if (!cs_lo) begin
            if (state != ST_IDLE) begin
                next_state = ST_IDLE;
                next_bitcnt = 3'h0;
                next_oe = 1'b0;
                next_wcmd = 1'b0;
                if (wcmd) begin
                    next_wen = 1'b0;
                end
                if (state == ST_SPECIAL) begin
                    case (opc)
                        `SWC_OP_SAVE: next_save = 1'b1;
                        `SWC_OP_RESTORE: next_rest = 1'b1;
                        `SWC_OP_AUTO_ON: next_auto = 1'b1;
                        `SWC_OP_AUTO_OFF: next_auto = 1'b0;
                        default: next_auto = auto_q;
                    endcase
                end
            end
        end else begin
            if (state == ST_IDLE) begin
                next_state = ST_OPC;
                next_bitcnt = 3'h0;
            end
            if (sck_rise) begin
                next_rx = byte_in;
                next_bitcnt = bitcnt + 3'h1;
            end
            if (byte_done) begin
                case (state)
                    ST_OPC: begin
                        next_opc = byte_in;
                        next_state = ST_IGNORE;
                        case (byte_in)
                            `SWC_OP_SET_WE: next_wen = 1'b1;
                            `SWC_OP_MEM_WRITE: begin
                                if (wen) begin
                                    next_state = ST_MADDR;
                                    next_abyte = 2'h0;
                                    next_wcmd = 1'b1;
                                end
                            end
                            `SWC_OP_CLK_READ, `SWC_OP_CLK_FREAD: next_state = ST_CADDR;
                            `SWC_OP_CLK_WRITE: begin
                                if (wen) begin
                                    next_state = ST_CADDR;
                                    next_wcmd = 1'b1;
                                end
                            end
                            `SWC_OP_SAVE, `SWC_OP_RESTORE,
                            `SWC_OP_AUTO_ON, `SWC_OP_AUTO_OFF: begin
                                if (wen) begin
                                    next_state = ST_SPECIAL;
                                    next_wcmd = 1'b1;
                                end
                            end
                            default: next_state = ST_IGNORE;
                        endcase
                    end
                    ST_MADDR: begin
                        next_abyte = abyte + 2'h1;
                        case (abyte)
                            2'h0: next_addr[16] = byte_in[0];
                            2'h1: next_addr[15:8] = byte_in;
                            default: begin
                                next_addr[7:0] = byte_in;
                                next_state = ST_MDATA;
                            end
                        endcase
                    end
                    ST_MDATA: begin
                        push = !is_prot(blk_prot, addr);
                        next_addr = addr + 17'h1;
                    end
                    ST_CADDR: begin
                        next_caddr = byte_in[3:0];
                        if (opc == `SWC_OP_CLK_READ) begin
                            next_state = ST_CRD;
                        end else if (opc == `SWC_OP_CLK_FREAD) begin
                            next_state = ST_DUMMY;
                        end else begin
                            next_state = ST_CWR;
                        end
                    end
                    ST_DUMMY: next_state = ST_CRD;
                    ST_CWR: begin
                        next_caddr = caddr + 4'h1;
                        if (caddr == `SWC_FLAG_IDX) begin
                            next_flags = byte_in;
                            if (!flags[`SWC_FLAG_R] && byte_in[`SWC_FLAG_R]) begin
                                next_snap = live_time;
                            end
                            if (flags[`SWC_FLAG_W] && !byte_in[`SWC_FLAG_W]) begin
                                next_load = 1'b1;
                            end
                        end else if (flags[`SWC_FLAG_W]) begin
                            if (caddr <= `SWC_TIME_LAST) begin
                                next_stage[{kidx, 3'h0} +: 8] = byte_in;
                            end else begin
                                rm.we = 1'b1;
                            end
                        end
                    end
                    default: next_state = state;
                endcase
            end
            if (sck_fall && state == ST_CRD) begin
                if (bitcnt == 3'h0) begin
                    next_tx = rbyte;
                    next_so = rbyte[7];
                    next_oe = 1'b1;
                    next_caddr = caddr + 4'h1;
                end else begin
                    next_so = tx[6];
                    next_tx = {tx[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            flags <= `SWC_FLAG_RST;
            auto_q <= `SWC_AUTOSAVE_RST;
            {bitcnt, rx, opc, tx, addr, abyte, caddr} <= '0;
            {wen, wcmd, so_q, oe_q, save_q, rest_q, load_q} <= '0;
            {snap, stage} <= '0;
        end else begin
            state <= next_state;
            flags <= next_flags;
            auto_q <= next_auto;
            {bitcnt, rx, opc, tx, addr, abyte, caddr} <= {next_bitcnt, next_rx, next_opc,
                next_tx, next_addr, next_abyte, next_caddr};
            {wen, wcmd, so_q, oe_q, save_q, rest_q, load_q} <= {next_wen, next_wcmd,
                next_so, next_oe, next_save, next_rest, next_load};
            {snap, stage} <= {next_snap, next_stage};
        end
    end

    assign so = so_q;
    assign so_oe = oe_q;
    assign write_enable = wen;
    assign autosave_on = auto_q;
    assign save_req = save_q;
    assign restore_req = rest_q;
    assign time_load = load_q;
    assign time_load_data = stage;

    // ==========================================================
    // two-entry write buffer toward the array
    swc_wr_t e0, e1, next_e0, next_e1;
    logic v0, v1, next_v0, next_v1, ovr, next_ovr, pop;

    assign push_ok = !v1;
    assign pop = v0 && mem_wr_ready;

    always_comb begin
        next_e0 = e0;
        next_e1 = e1;
        next_v0 = v0;
        next_v1 = v1;
        next_ovr = ovr || (push && !push_ok);
        if (pop) begin
            next_e0 = e1;
            next_v0 = v1;
            next_v1 = 1'b0;
        end
        if (push && push_ok) begin
            if (!next_v0) begin
                next_e0 = push_data;
                next_v0 = 1'b1;
            end else begin
                next_e1 = push_data;
                next_v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {e0, e1, v0, v1, ovr} <= '0;
        end else begin
            {e0, e1, v0, v1, ovr} <= {next_e0, next_e1, next_v0, next_v1, next_ovr};
        end
    end

    assign mem_wr_valid = v0;
    assign mem_wr_addr = e0[24:8];
    assign mem_wr_data = e0[7:0];
    assign wr_overrun = ovr;
endmodule : swc_engine

// File: design/swc_pkg.sv
// swc_pkg: shared types of the serial write and clock command engine
// assumes: state encodings are set here; opcodes and register indices come from swc_cfg.svh
package swc_pkg;
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_OPC = 10'h002,
        ST_MADDR = 10'h004,
        ST_MDATA = 10'h008,
        ST_CADDR = 10'h010,
        ST_DUMMY = 10'h020,
        ST_CRD = 10'h040,
        ST_CWR = 10'h080,
        ST_SPECIAL = 10'h100,
        ST_IGNORE = 10'h200
    } swc_state_t;
    typedef logic [55:0] swc_time_t;
    typedef logic [24:0] swc_wr_t;
endpackage : swc_pkg

// File: design/swc_regmem.sv
// swc_regmem: sixteen byte clock register store with registered read data
// assumes: mclk domain, asynchronous active high reset
`timescale 1ns/100ps
module swc_regmem #(
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst,
    swc_regmem_if.mem m
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] next_rdata;
    logic [7:0] rdata_q;

    assign m.rdata = rdata_q;

    always_comb begin
        next_rdata = mem_q[m.raddr];
    end

    always_ff @(posedge mclk) begin
        if (m.we) begin
            mem_q[m.waddr] <= m.wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= next_rdata;
        end
    end
endmodule : swc_regmem

// File: design/swc_regmem_if.sv
// swc_regmem_if: write and read port of the clock register memory
// assumes: one clock, driven by the engine, served by swc_regmem
`timescale 1ns/100ps
interface swc_regmem_if;
    logic we;
    logic [3:0] waddr;
    logic [7:0] wdata;
    logic [3:0] raddr;
    logic [7:0] rdata;
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : swc_regmem_if

// File: tb/swc_engine_monitor.sv
// swc_engine_monitor: port level checks of the serial command engine
// assumes: bound into swc_engine, one mclk domain, rst async high
`timescale 1ns/100ps
module swc_engine_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic so,
    input wire logic so_oe,
    input wire logic [1:0] blk_prot,
    input wire logic mem_wr_valid,
    input wire logic mem_wr_ready,
    input wire logic [16:0] mem_wr_addr,
    input wire logic [7:0] mem_wr_data,
    input wire logic write_enable,
    input wire logic autosave_on,
    input wire logic save_req,
    input wire logic restore_req,
    input wire logic time_load
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========
    // assertions
    chk_buf_hold: assert property (mem_wr_valid && !mem_wr_ready |=>
        mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
        else $error("stalled write entry changed");
    chk_prot_skip: assert property (mem_wr_valid |-> !(blk_prot == 2'h3 ||
        (blk_prot == 2'h2 && mem_wr_addr[16]) || (blk_prot == 2'h1 && &mem_wr_addr[16:15])))
        else $error("protected address written");
    chk_we_fall: assert property ($fell(write_enable) |-> cs_n && $past(cs_n))
        else $error("write enable cleared inside a frame");
    chk_we_rise: assert property ($rose(write_enable) |-> !cs_n && !$past(cs_n, 2))
        else $error("write enable set outside a frame");
    chk_special_we: assert property (save_req || restore_req |->
        $past(write_enable) && !write_enable)
        else $error("special command without write enable");
    chk_special_pulse: assert property (save_req || restore_req |=>
        !(save_req || restore_req))
        else $error("save or restore pulse too long");
    chk_auto_cs: assert property ($changed(autosave_on) |->
        cs_n && !write_enable && $past(write_enable))
        else $error("autosave changed without accepted command");
    chk_load_pulse: assert property (time_load |-> $past(write_enable) ##1 !time_load)
        else $error("time load pulse wrong");
    chk_oe_start: assert property ($rose(so_oe) |-> !cs_n && !sck)
        else $error("output enabled off a falling edge");
    chk_oe_end: assert property (cs_n [*5] |-> !so_oe)
        else $error("output enabled after deselect");
    chk_so_fall: assert property ($changed(so) && so_oe && $past(so_oe) |->
        !sck && !$past(sck))
        else $error("output changed while link clock high");
    cov_save: cover property (save_req);
    cov_load: cover property (time_load);
    cov_stall: cover property (mem_wr_valid && !mem_wr_ready);
    cov_read: cover property ($rose(so_oe));
endmodule : swc_engine_monitor

bind swc_engine swc_engine_monitor u_mon (.mclk, .rst, .cs_n, .sck, .so, .so_oe, .blk_prot,
    .mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_data, .write_enable, .autosave_on,
    .save_req, .restore_req, .time_load);

// File: tb/swc_engine_tb_top.sv
// swc_engine_tb_top: self-checking bench of the serial command engine
// assumes: swc_master drives the link, the bench plays the memory array
`timescale 1ns/100ps
module swc_engine_tb_top;
    import swc_pkg::*;
    logic mclk, rst, cs_n, sck, si, so, so_oe, mem_wr_valid, mem_wr_ready, hold;
    logic wr_overrun, write_enable, autosave_on, save_req, restore_req, time_load;
    logic [1:0] blk_prot;
    logic [16:0] mem_wr_addr;
    logic [7:0] mem_wr_data;
    logic [7:0] cr[16];
    logic [7:0] ops[4] = '{8'h19, 8'h59, 8'h3c, 8'h60};
    logic [7:0] r[$];
    logic [7:0] b[$];
    logic [31:0] d;
    swc_time_t live_time, time_load_data, t;
    swc_wr_t mq[$];
    swc_time_t tq[$];
    int error_cnt, checked, seed, n_save, n_rest;

    swc_engine dut (.mclk, .rst, .cs_n, .sck, .si, .so, .so_oe, .blk_prot, .live_time,
        .mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_data, .wr_overrun,
        .write_enable, .autosave_on, .save_req, .restore_req, .time_load, .time_load_data);
    // released output line shows the inverse of the last bit
    swc_master u_m (.mclk, .cs_n, .sck, .si, .so(so_oe ? so : ~so));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // ==========
    // helpers
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic fr(input logic [7:0] o[$], input int nr);
        logic [7:0] q;
        r = {};
        u_m.open_f();
        foreach (o[i]) u_m.xb(o[i], q);
        repeat (nr) begin
            u_m.xb(8'($random(seed)), q);
            r.push_back(q);
        end
        u_m.close_f();
    endtask : fr
    task automatic wen();
        fr({8'h06}, 0);
        chk(write_enable, 1'b1);
    endtask : wen
    task automatic drain();
        for (int i = 0; i < 900 && mq.size() > 0; i++) @(negedge mclk);
        chk(mq.size(), 0);
    endtask : drain
    // ==========
    // result watcher and array side
    always @(posedge mclk) begin
        if (mem_wr_valid && mem_wr_ready) begin
            if (mq.size() == 0) chk(1, 0);
            else chk({mem_wr_addr, mem_wr_data}, mq.pop_front());
        end
        if (time_load) begin
            if (tq.size() == 0) chk(1, 0);
            else chk(time_load_data, tq.pop_front());
        end
        if (save_req) n_save++;
        if (restore_req) n_rest++;
    end
    always @(negedge mclk) mem_wr_ready <= hold ? 1'b0 : 1'($random(seed));
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end
    // ==========
    // tests
    initial begin
        seed = 25242;
        {error_cnt, checked, n_save, n_rest} = '0;
        {rst, hold, blk_prot} = 4'h8;
        live_time = 56'({$random(seed), $random(seed)});
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        repeat (3) @(negedge mclk);
        chk({write_enable, autosave_on, mem_wr_valid, so_oe}, 4'h4);
        fr({8'h02, 8'h00, 8'h00, 8'h10, 8'h5a}, 0);
        fr({8'h3c}, 0);
        chk({write_enable, 4'(n_save)}, 5'h00);
        $display("refused frames done");
        wen();
        d = $random(seed);
        for (int i = 0; i < 3; i++) mq.push_back({17'(17'h1fffe + i), d[8*i+:8]});
        fr({8'h02, 8'hff, 8'hff, 8'hfe, d[7:0], d[15:8], d[23:16]}, 0);
        drain();
        chk(write_enable, 1'b0);
        for (int p = 0; p < 5; p++) begin
            blk_prot = (p == 4) ? 2'h1 : 2'(p);
            wen();
            d = $random(seed);
            if (p < 3) mq.push_back({17'h0ffff, d[7:0]});
            if (p < 2) mq.push_back({17'h10000, d[15:8]});
            if (p == 4) mq.push_back({17'h00000, d[15:8]});
            fr({8'h02, 8'(p == 4), 8'hff, 8'hff, d[7:0], d[15:8]}, 0);
            drain();
        end
        blk_prot = 2'h0;
        $display("memory write tests done");
        wen();
        fr({8'h12, 8'h00, 8'h02}, 0);
        chk(write_enable, 1'b0);
        wen();
        b = {8'h12, 8'h08};
        for (int i = 8; i < 24; i++) begin
            cr[i%16] = (i == 16) ? 8'h02 : 8'($random(seed));
            b.push_back(cr[i%16]);
        end
        for (int k = 1; k < 8; k++) t[8*k-8+:8] = cr[k];
        tq.push_back(t);
        fr(b, 0);
        wen();
        fr({8'h12, 8'h00, 8'h00}, 0);
        chk(tq.size(), 0);
        wen();
        fr({8'h12, 8'h08, ~cr[8]}, 0);
        wen();
        fr({8'h12, 8'h00, 8'h01}, 0);
        fr({8'h13, 8'h08}, 10);
        for (int i = 0; i < 8; i++) chk(r[i], cr[8+i]);
        chk(r[8], 8'h01);
        chk(r[9], live_time[7:0]);
        $display("clock write and read done");
        t = live_time;
        wen();
        fr({8'h12, 8'h00, 8'h01}, 0);
        live_time = ~t;
        fr({8'h1d, 8'h0f, 8'($random(seed))}, 9);
        chk(r[0], cr[15]);
        chk(r[1], 8'h01);
        for (int k = 1; k < 8; k++) chk(r[k+1], t[8*k-8+:8]);
        wen();
        fr({8'h12, 8'h00, 8'h00}, 0);
        $display("snapshot fast read done");
        foreach (ops[i]) begin
            wen();
            fr({ops[i]}, 0);
            chk({write_enable, autosave_on, 4'(n_save), 4'(n_rest)},
                {1'b0, 1'(i != 0), 4'(i >= 2), 4'(i == 3)});
        end
        $display("special commands done");
        hold = 1'b1;
        wen();
        d = $random(seed);
        mq.push_back({17'h00100, d[7:0]});
        mq.push_back({17'h00101, d[15:8]});
        fr({8'h02, 8'h00, 8'h01, 8'h00, d[7:0], d[15:8], d[23:16]}, 0);
        chk(wr_overrun, 1'b1);
        hold = 1'b0;
        drain();
        rst = 1'b1;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        repeat (3) @(negedge mclk);
        chk({wr_overrun, write_enable, autosave_on, mem_wr_valid}, 4'h2);
        $display("buffer and reset done");
        give_verdict();
    end
endmodule : swc_engine_tb_top

// File: tb/swc_master.sv
// swc_master: link master, mode 0, 125 ns bit period
// assumes: mclk from the bench; all pins step on mclk falling edges
`timescale 1ns/100ps
module swc_master (
    input wire logic mclk,
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    task automatic hw(input int n);
        repeat (n) @(negedge mclk);
    endtask : hw
    // ==========
    // frames and bytes
    task automatic open_f();
        cs_n = 1'b0;
        hw(12);
    endtask : open_f
    task automatic xb(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            si = d[i];
            hw(12);
            sck = 1'b1;
            q[i] = so;
            hw(13);
            sck = 1'b0;
        end
    endtask : xb
    // select drops right after the last bit, data line left toggled
    task automatic close_f();
        hw(4);
        cs_n = 1'b1;
        si = ~si;
        hw(24);
    endtask : close_f
endmodule : swc_master
